/* File: pkg/crp_pkg.sv */
package crp_pkg;
  // Embedded-processor access widths and routed pin counts
  localparam int unsigned XADDR_W = 16;
  localparam int unsigned SADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ROUTE_PINS = 8;
  localparam int unsigned UPPER_PINS = 4;

  // Special-function register space
  localparam logic [7:0] SFR_PIN_DIRECTION_UPPER = 8'ha2;

  // External data region, configuration window 2xxx
  localparam logic [3:0] XDATA_REGION = 4'h2;
  localparam logic [15:0] XA_ENGINE_CONTROL = 16'h2000;
  localparam logic [15:0] XA_CHOP_CONTROL = 16'h2002;
  localparam logic [15:0] XA_RESERVED_MISC = 16'h2003;
  localparam logic [15:0] XA_CLOCK_OUTPUT_CONTROL = 16'h2004;
  localparam logic [15:0] XA_CONVERTER_POWER = 16'h2005;
  localparam logic [15:0] XA_PIN_OPTION = 16'h2008;
  localparam logic [15:0] XA_PIN_ROUTE_4_5 = 16'h200b;
  localparam logic [15:0] XA_PIN_ROUTE_6_7 = 16'h200c;
  localparam logic [15:0] XA_PIN_ROUTE_8_9 = 16'h200d;
  localparam logic [15:0] XA_PIN_ROUTE_10_11 = 16'h200e;

  // Field positions
  localparam int unsigned ENGINE_ENABLE_BIT = 4;
  localparam int unsigned ENGINE_EQU_LSB = 5;
  localparam int unsigned CHOP_LSB = 4;
  localparam int unsigned TEST_CLOCK_DISABLE_BIT = 4;
  localparam int unsigned CONVERTER_DISABLE_BIT = 3;
  localparam int unsigned VAR_PULSE_OPTION_BIT = 2;
  localparam int unsigned WATT_PULSE_OPTION_BIT = 3;
  localparam int unsigned EEPROM_OPTION_BIT = 4;
  localparam int unsigned DIRECTION_LSB = 4;

  // Writable masks; other bits read back as zero, except misc bits 2:0 which return status
  localparam logic [7:0] MISC_WRITE_MASK = 8'h18;
  localparam logic [7:0] MISC_READ_ONLY_MASK = 8'h07;
  localparam logic [7:0] ROUTE_WRITE_MASK = 8'h77;
  localparam logic [7:0] PIN_OPTION_WRITE_MASK = 8'h1c;

  // Values after power-up
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // Pin resource codes
  typedef enum logic [2:0] {
    CRP_RES_NONE = 3'b000,
    CRP_RES_RSVD = 3'b001,
    CRP_RES_TIMER0 = 3'b010,
    CRP_RES_TIMER1 = 3'b011,
    CRP_RES_HI_RISE = 3'b100,
    CRP_RES_LO_RISE = 3'b101,
    CRP_RES_HI_FALL = 3'b110,
    CRP_RES_LO_FALL = 3'b111
  } crp_resource_t;
endpackage

/* File: core/crp_pin_edge.sv */
`timescale 1ns/1ps
`default_nettype none
// One routed pin: edge detection and resource decode
module crp_pin_edge
  import crp_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Pin level and its selector
  input wire logic i_pin,
  input wire logic [2:0] i_resource_code,
  // Per-pin resource requests
  output logic o_timer_zero,
  output logic o_timer_one,
  output logic o_high_event,
  output logic o_low_event
);
  logic last_level;
  logic next_last_level;
  logic rise;
  logic fall;

  // Previous level for edge detection
  always_comb begin
    next_last_level = i_pin;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      last_level <= 1'b0;
    end else begin
      last_level <= next_last_level;
    end
  end

  assign rise = i_pin & ~last_level;
  assign fall = ~i_pin & last_level;

  // Decode of the selector; none and reserved connect nothing
  always_comb begin
    o_timer_zero = 1'b0;
    o_timer_one = 1'b0;
    o_high_event = 1'b0;
    o_low_event = 1'b0;
    unique case (crp_resource_t'(i_resource_code))
      CRP_RES_NONE, CRP_RES_RSVD: begin
        o_timer_zero = 1'b0;
      end
      CRP_RES_TIMER0: o_timer_zero = i_pin;
      CRP_RES_TIMER1: o_timer_one = i_pin;
      CRP_RES_HI_RISE: o_high_event = rise;
      CRP_RES_LO_RISE: o_low_event = rise;
      CRP_RES_HI_FALL: o_high_event = fall;
      CRP_RES_LO_FALL: o_low_event = fall;
    endcase
  end
endmodule
`default_nettype wire

/* File: core/crp_pin_drive.sv */
`timescale 1ns/1ps
`default_nettype none
// Output selection for one of pins 4 to 7
module crp_pin_drive (
  // Configuration
  input wire logic i_gpio_mode,
  input wire logic i_direction_out,
  input wire logic i_alt_enable,
  input wire logic i_alt_value,
  input wire logic i_alt_oe,
  input wire logic i_alt_forced,
  // Port value
  input wire logic i_port_value,
  // Pad controls
  output logic o_value,
  output logic o_oe
);
  // Forced alternates own the pad; others need an output direction
  always_comb begin
    o_value = 1'b0;
    o_oe = 1'b0;
    if (i_alt_forced) begin
      o_value = i_alt_value;
      o_oe = i_alt_oe;
    end else if (i_gpio_mode && i_direction_out) begin
      o_oe = 1'b1;
      o_value = i_alt_enable ? i_alt_value : i_port_value;
    end
  end
endmodule
`default_nettype wire

/* File: core/crp_config_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - All configuration bits clear to zero at reset.
// - Read-only fields ignore writes and only return values.
// - Direction sits in special-function space; the rest decode at 2xxx.
// - Engine parameters come straight from configuration register contents.
// - Converter disable bit drives the converter and bias shut-off output.
// - Chop codes 00 and 11 enable chopping; 01 and 10 disable it.
// - Test clock pin driven while its disable bit is zero.
// - Selector 0 none, 1 reserved, 2 timer zero clock, 3 timer one.
// - Codes 4 and 6: high-priority interrupt on rising, falling edge.
// - Codes 5 and 7: low-priority interrupt on rising, falling edge.
// - Pins sharing one resource are ORed together.
// - Upper direction bit 1 makes pin 4..7 an output, 0 an input.
// - Direction ignored when pin is not general-purpose I/O.
// - Watt option with pin 6 output drives the energy pulse.
// - VAR option with pin 7 output drives the reactive pulse.
// - EEPROM option makes pin 4 serial clock, pin 5 serial data.
module crp_config_bank
  import crp_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // External data access from the embedded processor
  input wire logic [15:0] i_xdata_addr,
  input wire logic i_xdata_wr,
  input wire logic i_xdata_rd,
  // Special-function register access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  // Shared write data and read data
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // Read-only status shown in the misc register
  input wire logic [2:0] i_misc_status,
  // Routed pins 4 to 11 and the modes of pins 4 to 7
  input wire logic [7:0] i_pin,
  input wire logic [3:0] i_upper_gpio_mode,
  input wire logic [3:0] i_port_value,
  // Pulse and EEPROM sources
  input wire logic i_energy_pulse,
  input wire logic i_reactive_pulse,
  input wire logic i_eeprom_scl,
  input wire logic i_eeprom_sda_out,
  input wire logic i_eeprom_sda_oe,
  input wire logic i_test_clock_src,
  // Pins 4 to 7 pad controls
  output logic [3:0] o_upper_pin_out,
  output logic [3:0] o_upper_pin_oe,
  output logic o_eeprom_sda_in,
  // Resources fed by pins
  output logic o_timer_zero_clock,
  output logic o_timer_one_clock,
  output logic o_high_priority_ext_interrupt,
  output logic o_low_priority_ext_interrupt,
  // Analog and engine controls
  output logic o_converter_disable,
  output logic o_chop_active,
  output logic o_engine_enable,
  output logic [2:0] o_engine_equation,
  output logic o_test_clock_pin,
  output logic o_test_clock_pin_oe
);
  // Configuration storage
  logic [7:0] pin_direction_upper;
  logic [7:0] engine_control;
  logic [7:0] chop_control;
  logic [7:0] reserved_misc;
  logic [7:0] clock_output_control;
  logic [7:0] converter_power;
  logic [7:0] pin_option;
  logic [7:0] pin_route [4];
  logic [7:0] next_pin_direction_upper;
  logic [7:0] next_engine_control;
  logic [7:0] next_chop_control;
  logic [7:0] next_reserved_misc;
  logic [7:0] next_clock_output_control;
  logic [7:0] next_converter_power;
  logic [7:0] next_pin_option;
  logic [7:0] next_pin_route [4];

  // Read path
  logic [7:0] rdata;
  logic rdata_valid;
  logic [7:0] next_rdata;
  logic next_rdata_valid;

  // Resource and pad outputs
  logic [7:0] timer_zero_req;
  logic [7:0] timer_one_req;
  logic [7:0] high_req;
  logic [7:0] low_req;
  logic [3:0] pad_value;
  logic [3:0] pad_oe;
  logic timer_zero_clock;
  logic timer_one_clock;
  logic high_irq;
  logic low_irq;
  logic [3:0] upper_pin_out;
  logic [3:0] upper_pin_oe;
  logic eeprom_sda_in;
  logic test_clock_pin;
  logic test_clock_pin_oe;
  logic chop_active;
  logic next_timer_zero_clock;
  logic next_timer_one_clock;
  logic next_high_irq;
  logic next_low_irq;
  logic [3:0] next_upper_pin_out;
  logic [3:0] next_upper_pin_oe;
  logic next_eeprom_sda_in;
  logic next_test_clock_pin;
  logic next_test_clock_pin_oe;
  logic next_chop_active;

  logic xdata_hit;
  logic eeprom_mode;
  logic [3:0] alt_enable;
  logic [3:0] alt_value;
  logic [3:0] alt_oe;
  logic [3:0] alt_forced;

  assign xdata_hit = (i_xdata_addr[15:12] == XDATA_REGION);
  assign eeprom_mode = pin_option[EEPROM_OPTION_BIT];

  // Register writes; only writable bits take the data
  always_comb begin
    next_pin_direction_upper = pin_direction_upper;
    next_engine_control = engine_control;
    next_chop_control = chop_control;
    next_reserved_misc = reserved_misc;
    next_clock_output_control = clock_output_control;
    next_converter_power = converter_power;
    next_pin_option = pin_option;
    for (int k = 0; k < 4; k++) begin
      next_pin_route[k] = pin_route[k];
    end
    if (i_sfr_wr && (i_sfr_addr == SFR_PIN_DIRECTION_UPPER)) begin
      next_pin_direction_upper = i_wdata;
    end
    if (i_xdata_wr && xdata_hit) begin
      unique case (i_xdata_addr)
        XA_ENGINE_CONTROL: next_engine_control = i_wdata;
        XA_CHOP_CONTROL: next_chop_control = i_wdata;
        XA_RESERVED_MISC: next_reserved_misc = i_wdata & MISC_WRITE_MASK;
        XA_CLOCK_OUTPUT_CONTROL: next_clock_output_control = i_wdata;
        XA_CONVERTER_POWER: next_converter_power = i_wdata;
        XA_PIN_OPTION: next_pin_option = i_wdata & PIN_OPTION_WRITE_MASK;
        XA_PIN_ROUTE_4_5: next_pin_route[0] = i_wdata & ROUTE_WRITE_MASK;
        XA_PIN_ROUTE_6_7: next_pin_route[1] = i_wdata & ROUTE_WRITE_MASK;
        XA_PIN_ROUTE_8_9: next_pin_route[2] = i_wdata & ROUTE_WRITE_MASK;
        XA_PIN_ROUTE_10_11: next_pin_route[3] = i_wdata & ROUTE_WRITE_MASK;
        default: next_pin_option = pin_option;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_direction_upper <= CONFIG_RESET;
      engine_control <= CONFIG_RESET;
      chop_control <= CONFIG_RESET;
      reserved_misc <= CONFIG_RESET;
      clock_output_control <= CONFIG_RESET;
      converter_power <= CONFIG_RESET;
      pin_option <= CONFIG_RESET;
      for (int k = 0; k < 4; k++) begin
        pin_route[k] <= CONFIG_RESET;
      end
    end else begin
      pin_direction_upper <= next_pin_direction_upper;
      engine_control <= next_engine_control;
      chop_control <= next_chop_control;
      reserved_misc <= next_reserved_misc;
      clock_output_control <= next_clock_output_control;
      converter_power <= next_converter_power;
      pin_option <= next_pin_option;
      for (int k = 0; k < 4; k++) begin
        pin_route[k] <= next_pin_route[k];
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_comb begin
    next_rdata = 8'h00;
    next_rdata_valid = i_sfr_rd | i_xdata_rd;
    if (i_sfr_rd && (i_sfr_addr == SFR_PIN_DIRECTION_UPPER)) begin
      next_rdata = pin_direction_upper;
    end else if (i_xdata_rd && xdata_hit) begin
      unique case (i_xdata_addr)
        XA_ENGINE_CONTROL: next_rdata = engine_control;
        XA_CHOP_CONTROL: next_rdata = chop_control;
        XA_RESERVED_MISC: next_rdata = reserved_misc | {5'h00, i_misc_status};
        XA_CLOCK_OUTPUT_CONTROL: next_rdata = clock_output_control;
        XA_CONVERTER_POWER: next_rdata = converter_power;
        XA_PIN_OPTION: next_rdata = pin_option;
        XA_PIN_ROUTE_4_5: next_rdata = pin_route[0];
        XA_PIN_ROUTE_6_7: next_rdata = pin_route[1];
        XA_PIN_ROUTE_8_9: next_rdata = pin_route[2];
        XA_PIN_ROUTE_10_11: next_rdata = pin_route[3];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
    end
  end

  // One edge detector and decoder per routed pin
  for (genvar p = 0; p < ROUTE_PINS; p++) begin : g_route
    crp_pin_edge u_edge (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_pin(i_pin[p]),
      .i_resource_code(pin_route[p / 2][(p % 2) * 4 +: 3]),
      .o_timer_zero(timer_zero_req[p]),
      .o_timer_one(timer_one_req[p]),
      .o_high_event(high_req[p]),
      .o_low_event(low_req[p])
    );
  end

  // Alternate uses of pins 4 to 7
  always_comb begin
    alt_enable = 4'h0;
    alt_value = 4'h0;
    alt_oe = 4'h0;
    alt_forced = 4'h0;
    alt_forced[0] = eeprom_mode;
    alt_value[0] = i_eeprom_scl;
    alt_oe[0] = 1'b1;
    alt_forced[1] = eeprom_mode;
    alt_value[1] = 1'b0; // Open drain: pull low only
    alt_oe[1] = i_eeprom_sda_oe & ~i_eeprom_sda_out;
    alt_enable[2] = pin_option[WATT_PULSE_OPTION_BIT];
    alt_value[2] = i_energy_pulse;
    alt_enable[3] = pin_option[VAR_PULSE_OPTION_BIT];
    alt_value[3] = i_reactive_pulse;
  end

  for (genvar u = 0; u < UPPER_PINS; u++) begin : g_upper
    crp_pin_drive u_drive (
      .i_gpio_mode(i_upper_gpio_mode[u]),
      .i_direction_out(pin_direction_upper[DIRECTION_LSB + u]),
      .i_alt_enable(alt_enable[u]),
      .i_alt_value(alt_value[u]),
      .i_alt_oe(alt_oe[u]),
      .i_alt_forced(alt_forced[u]),
      .i_port_value(i_port_value[u]),
      .o_value(pad_value[u]),
      .o_oe(pad_oe[u])
    );
  end

  // Resource merge and pad registers
  always_comb begin
    next_timer_zero_clock = |timer_zero_req;
    next_timer_one_clock = |timer_one_req;
    next_high_irq = |high_req;
    next_low_irq = |low_req;
    next_upper_pin_out = pad_value;
    next_upper_pin_oe = pad_oe;
    next_eeprom_sda_in = i_pin[1];
    next_test_clock_pin = i_test_clock_src;
    next_test_clock_pin_oe = ~clock_output_control[TEST_CLOCK_DISABLE_BIT];
    // Chop decode taken from the next value so it lands with the write
    next_chop_active = ~^next_chop_control[CHOP_LSB +: 2];
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      timer_zero_clock <= 1'b0;
      timer_one_clock <= 1'b0;
      high_irq <= 1'b0;
      low_irq <= 1'b0;
      upper_pin_out <= 4'h0;
      upper_pin_oe <= 4'h0;
      eeprom_sda_in <= 1'b0;
      test_clock_pin <= 1'b0;
      test_clock_pin_oe <= 1'b0;
      chop_active <= ~^CONFIG_RESET[CHOP_LSB +: 2];
    end else begin
      timer_zero_clock <= next_timer_zero_clock;
      timer_one_clock <= next_timer_one_clock;
      high_irq <= next_high_irq;
      low_irq <= next_low_irq;
      upper_pin_out <= next_upper_pin_out;
      upper_pin_oe <= next_upper_pin_oe;
      eeprom_sda_in <= next_eeprom_sda_in;
      test_clock_pin <= next_test_clock_pin;
      test_clock_pin_oe <= next_test_clock_pin_oe;
      chop_active <= next_chop_active;
    end
  end

  // Control outputs from configuration flops and the registered chop decode
  assign o_converter_disable = converter_power[CONVERTER_DISABLE_BIT];
  assign o_chop_active = chop_active;
  assign o_engine_enable = engine_control[ENGINE_ENABLE_BIT];
  assign o_engine_equation = engine_control[ENGINE_EQU_LSB +: 3];
  assign o_rdata = rdata;
  assign o_rdata_valid = rdata_valid;
  assign o_timer_zero_clock = timer_zero_clock;
  assign o_timer_one_clock = timer_one_clock;
  assign o_high_priority_ext_interrupt = high_irq;
  assign o_low_priority_ext_interrupt = low_irq;
  assign o_upper_pin_out = upper_pin_out;
  assign o_upper_pin_oe = upper_pin_oe;
  assign o_eeprom_sda_in = eeprom_sda_in;
  assign o_test_clock_pin = test_clock_pin;
  assign o_test_clock_pin_oe = test_clock_pin_oe;
endmodule
`default_nettype wire

/* File: bench/crp_config_bank_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the configuration bank
module crp_config_bank_props
  import crp_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register access
  input wire logic [15:0] i_xdata_addr,
  input wire logic i_xdata_wr,
  input wire logic i_xdata_rd,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_valid,
  input wire logic [2:0] i_misc_status,
  // Controls
  input wire logic i_test_clock_src,
  input wire logic o_converter_disable,
  input wire logic o_chop_active,
  input wire logic o_engine_enable,
  input wire logic [2:0] o_engine_equation,
  input wire logic o_test_clock_pin
);
  default clocking cb @(posedge i_sys_clk);
  endclocking

  // External-data write and read to one address
  sequence s_xwr(logic [15:0] a);
    i_xdata_wr && i_xdata_addr == a;
  endsequence
  sequence s_xrd(logic [15:0] a);
    i_xdata_rd && !i_sfr_rd && i_xdata_addr == a;
  endsequence

  chk_reset_clear: assert property (
    i_rst |=> !o_rdata_valid && o_rdata == 8'h00 && !o_converter_disable && !o_engine_enable
      && o_engine_equation == 3'h0) else $error("outputs not clear after reset");
  chk_valid_pulse: assert property (disable iff (i_rst)
    1'b1 |=> o_rdata_valid == $past(i_xdata_rd || i_sfr_rd)) else $error("read valid pulse wrong");
  chk_unmapped_zero: assert property (disable iff (i_rst)
    s_xrd(16'h2001) |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  chk_status_read: assert property (disable iff (i_rst)
    s_xrd(XA_RESERVED_MISC) |=> o_rdata[2:0] == $past(i_misc_status)) else $error("status bits wrong");
  chk_conv_readback: assert property (disable iff (i_rst)
    s_xrd(XA_CONVERTER_POWER) |=> o_rdata[3] == $past(o_converter_disable)) else $error("readback wrong");
  chk_conv_write: assert property (disable iff (i_rst)
    s_xwr(XA_CONVERTER_POWER) |=> o_converter_disable == $past(i_wdata[3])) else $error("converter off wrong");
  chk_chop_code: assert property (disable iff (i_rst)
    s_xwr(XA_CHOP_CONTROL) |=> o_chop_active == ~^$past(i_wdata[5:4])) else $error("chop decode wrong");
  chk_engine_run: assert property (disable iff (i_rst)
    s_xwr(XA_ENGINE_CONTROL) |=> o_engine_enable == $past(i_wdata[4])) else $error("engine enable wrong");
  chk_engine_equ: assert property (disable iff (i_rst)
    s_xwr(XA_ENGINE_CONTROL) |=> o_engine_equation == $past(i_wdata[7:5])) else $error("equation wrong");
  chk_test_clock: assert property (disable iff (i_rst)
    1'b1 |=> o_test_clock_pin == $past(i_test_clock_src)) else $error("test clock not mirrored");
endmodule

bind crp_config_bank crp_config_bank_props i_props (.i_sys_clk, .i_rst, .i_xdata_addr, .i_xdata_wr,
  .i_xdata_rd, .i_sfr_rd, .i_wdata, .o_rdata, .o_rdata_valid, .i_misc_status, .i_test_clock_src,
  .o_converter_disable, .o_chop_active, .o_engine_enable, .o_engine_equation, .o_test_clock_pin);
`default_nettype wire

/* File: bench/test_config_ram_pin_routing.sv */
`timescale 1ns/1ps
`default_nettype none
// Register and pin routing bench for the configuration bank
module test_config_ram_pin_routing
  import crp_pkg::*;
;
  // Design inputs
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_xdata_wr = 1'b0, i_xdata_rd = 1'b0, i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0, i_energy_pulse = 1'b0, i_reactive_pulse = 1'b0, i_eeprom_scl = 1'b0;
  logic i_eeprom_sda_out = 1'b0, i_eeprom_sda_oe = 1'b0, i_test_clock_src = 1'b0;
  logic [15:0] i_xdata_addr = 16'h0000;
  logic [7:0] i_sfr_addr = 8'h00, i_wdata = 8'h00, i_pin = 8'h00;
  logic [2:0] i_misc_status = 3'h0;
  logic [3:0] i_upper_gpio_mode = 4'h0, i_port_value = 4'h0;
  // Design outputs
  logic [7:0] o_rdata;
  logic [3:0] o_upper_pin_out, o_upper_pin_oe;
  logic [2:0] o_engine_equation;
  logic o_rdata_valid, o_eeprom_sda_in, o_timer_zero_clock, o_timer_one_clock, o_converter_disable;
  logic o_high_priority_ext_interrupt, o_low_priority_ext_interrupt, o_chop_active, o_engine_enable;
  logic o_test_clock_pin, o_test_clock_pin_oe;
  int n_mismatch = 0, samples_checked = 0;
  // Resource outputs packed as timer zero, timer one, high, low
  wire logic [7:0] res = {4'h0, o_timer_zero_clock, o_timer_one_clock, o_high_priority_ext_interrupt,
    o_low_priority_ext_interrupt};
  logic [15:0] ra [10] = '{XA_ENGINE_CONTROL, XA_CHOP_CONTROL, XA_RESERVED_MISC, XA_CLOCK_OUTPUT_CONTROL,
    XA_CONVERTER_POWER, XA_PIN_OPTION, XA_PIN_ROUTE_4_5, XA_PIN_ROUTE_6_7, XA_PIN_ROUTE_8_9, XA_PIN_ROUTE_10_11};
  logic [7:0] rw [10] = '{8'hff, 8'h30, 8'h07, 8'h10, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] rx [10] = '{8'hff, 8'h30, 8'h05, 8'h10, 8'h08, 8'h1c, 8'h77, 8'h77, 8'h77, 8'h77};

  crp_config_bank i_dut (.i_sys_clk, .i_rst, .i_xdata_addr, .i_xdata_wr, .i_xdata_rd, .i_sfr_addr,
    .i_sfr_wr, .i_sfr_rd, .i_wdata, .o_rdata, .o_rdata_valid, .i_misc_status, .i_pin, .i_upper_gpio_mode,
    .i_port_value, .i_energy_pulse, .i_reactive_pulse, .i_eeprom_scl, .i_eeprom_sda_out, .i_eeprom_sda_oe,
    .i_test_clock_src, .o_upper_pin_out, .o_upper_pin_oe, .o_eeprom_sda_in, .o_timer_zero_clock,
    .o_timer_one_clock, .o_high_priority_ext_interrupt, .o_low_priority_ext_interrupt, .o_converter_disable,
    .o_chop_active, .o_engine_enable, .o_engine_equation, .o_test_clock_pin, .o_test_clock_pin_oe);

  // Clock at 100 MHz
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Byte compare with count
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Wait edges, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // One register access; a read compares against d
  task automatic acc(input bit special_function_register, input bit wr, input logic [15:0] a, input logic [7:0] d);
    tick(1);
    i_xdata_addr = a;
    i_sfr_addr = a[7:0];
    i_wdata = d;
    i_xdata_wr = wr & !special_function_register;
    i_xdata_rd = !wr & !special_function_register;
    i_sfr_wr = wr & special_function_register;
    i_sfr_rd = !wr & special_function_register;
    tick(1);
    {i_xdata_wr, i_xdata_rd, i_sfr_wr, i_sfr_rd} = 4'h0;
    if (!wr) begin
      check("read valid", 8'h01, {7'h0, o_rdata_valid});
      check("read data", d, o_rdata);
    end
  endtask

  // Move the routed pins and let one edge sample them
  task automatic pin_to(input logic [7:0] v);
    tick(1);
    i_pin = v;
    tick(1);
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    tick(1);
    check("test clock oe", 8'h01, {7'h0, o_test_clock_pin_oe});
    for (int i = 0; i < 10; i++) acc(0, 0, ra[i], 8'h00);
    acc(1, 0, 16'h00a2, 8'h00);
    i_misc_status = 3'h5;
    for (int i = 0; i < 10; i++) acc(0, 1, ra[i], rw[i]);
    for (int i = 0; i < 10; i++) acc(0, 0, ra[i], rx[i]);
    tick(1);
    check("converter off", 8'h01, {7'h0, o_converter_disable});
    check("engine", 8'h0f, {4'h0, o_engine_enable, o_engine_equation});
    check("test clock oe", 8'h00, {7'h0, o_test_clock_pin_oe});
    acc(0, 1, XA_ENGINE_CONTROL, 8'hb0);
    check("engine", 8'h0d, {4'h0, o_engine_enable, o_engine_equation});
    for (int c = 0; c < 4; c++) begin
      acc(0, 1, XA_CHOP_CONTROL, {2'b00, c[1:0], 4'h0});
      check("chop", {7'h0, c[1] == c[0]}, {7'h0, o_chop_active});
    end
    acc(0, 1, XA_CLOCK_OUTPUT_CONTROL, 8'h00);
    i_test_clock_src = 1'b1;
    tick(2);
    check("test clock", 8'h03, {6'h0, o_test_clock_pin_oe, o_test_clock_pin});
    acc(0, 0, 16'h2001, 8'h00);
    acc(1, 0, 16'h0080, 8'h00);
    acc(0, 1, 16'h3005, 8'h00);
    acc(0, 0, XA_CONVERTER_POWER, 8'h08);
    acc(0, 1, XA_CONVERTER_POWER, 8'h00);
    check("converter off", 8'h00, {7'h0, o_converter_disable});
    // Every resource code on pin 4, both edges
    for (int c = 0; c < 8; c++) begin
      acc(0, 1, XA_PIN_ROUTE_4_5, {5'h0, c[2:0]});
      pin_to(8'h01);
      check("rise", {4'h0, c == 2, c == 3, c == 4, c == 5}, res);
      tick(1);
      check("after rise", {4'h0, c == 2, c == 3, 2'b00}, res);
      pin_to(8'h00);
      check("fall", {6'h0, c == 6, c == 7}, res);
      tick(1);
      check("after fall", 8'h00, res);
    end
    // Shared resources across pins
    acc(0, 1, XA_PIN_ROUTE_4_5, 8'h32);
    acc(0, 1, XA_PIN_ROUTE_8_9, 8'h20);
    acc(0, 1, XA_PIN_ROUTE_10_11, 8'h05);
    pin_to(8'h22);
    check("or timers", 8'h0c, res);
    pin_to(8'h62);
    check("or interrupt", 8'h0d, res);
    // Direction, mode and alternate pin uses
    acc(0, 1, XA_PIN_OPTION, 8'h00);
    i_upper_gpio_mode = 4'hf;
    i_port_value = 4'ha;
    acc(1, 1, 16'h00a2, 8'h3f);
    acc(1, 0, 16'h00a2, 8'h3f);
    tick(1);
    check("dir oe", 8'h03, {4'h0, o_upper_pin_oe});
    check("dir out", 8'h02, {6'h0, o_upper_pin_out[1:0]});
    i_upper_gpio_mode = 4'he;
    tick(2);
    check("display pin", 8'h02, {4'h0, o_upper_pin_oe});
    i_upper_gpio_mode = 4'hf;
    i_energy_pulse = 1'b1;
    acc(1, 1, 16'h00a2, 8'hff);
    acc(0, 1, XA_PIN_OPTION, 8'h0c);
    tick(1);
    check("pulses", 8'h1e, {3'h0, o_upper_pin_oe, o_upper_pin_out[3]});
    check("energy pulse", 8'h01, {7'h0, o_upper_pin_out[2]});
    i_eeprom_scl = 1'b1;
    i_eeprom_sda_oe = 1'b1;
    i_pin = 8'h02;
    acc(0, 1, XA_PIN_OPTION, 8'h10);
    tick(1);
    check("eeprom pins", 8'h0f, {3'h0, o_upper_pin_out[1:0], o_upper_pin_oe[1:0], o_eeprom_sda_in});
    i_eeprom_sda_out = 1'b1;
    tick(2);
    check("sda released", 8'h00, {7'h0, o_upper_pin_oe[1]});
    results();
  end
endmodule
`default_nettype wire
